// *** core/smdf_core.sv ***
/*
 * Serial word capture with data and sign masks, plus the character
 * layout of the title, data and unit fields of a 1- or 2-line module.
 * Assumes synchronous inputs, one clock, byte register port with read
 * data one cycle after the read strobe, BCD digits from a converter.
 */
`timescale 1ns/10ps
module smdf_core
	import smdf_pkg::*;
#(
	parameter int MAG_W = 32	// Width of delivered magnitude
) (
	input  wire logic              clock,            // 100 MHz clock
	input  wire logic              rst_n,            // Async reset, low
	input  wire logic [7:0]        reg_addr,         // Register address
	input  wire logic [7:0]        reg_wr_data,      // Register write data
	input  wire logic              reg_wr_stb,       // Write strobe
	input  wire logic              reg_rd_stb,       // Read strobe
	output logic      [7:0]        reg_rd_data,      // Read data, next cycle
	input  wire logic              word_select_n,    // Word select, low active
	input  wire logic              serial_bit_in,    // Serial data in
	output logic                   serial_strobe,    // Bit acknowledge strobe
	output logic      [MAG_W-1:0]  magnitude,        // Right-aligned data
	output logic                   sign_negative,    // Captured sign
	output logic                   result_valid,     // One-cycle word done
	output logic                   two_line_mode,    // 2-line module chosen
	output logic                   low_emission,     // Low frequency mode
	input  wire logic [4*DIGITS-1:0] bcd_digits,     // Converter digits, MSD top
	input  wire logic [2:0]        point_after,      // Digits before point
	input  wire logic [4:0]        char_index,       // Line*16 + column
	output logic      [7:0]        char_code         // Character, next cycle
);

	// Configuration storage
	logic [3:0] setup_q, setup_d;
	logic [3:0] mode_q, mode_d;
	logic [7:0] title_q [TITLE_CHARS];
	logic [7:0] title_d [TITLE_CHARS];
	logic [7:0] unit_q [UNIT_CHARS];
	logic [7:0] unit_d [UNIT_CHARS];
	logic [31:0] data_mask_q, data_mask_d;
	logic [31:0] sign_mask_q, sign_mask_d;
	logic [7:0] rd_q, rd_d;

	// Capture state
	smdf_state_e state_q, state_d;
	logic [5:0]  div_q, div_d;
	logic [5:0]  bits_q, bits_d;
	logic [31:0] shift_q, shift_d;
	logic        strobe_q, strobe_d;
	logic        pin_q, pin_d;
	logic [MAG_W-1:0] mag_q, mag_d;
	logic        neg_q, neg_d;
	logic        valid_q, valid_d;
	logic [5:0]  len_q, len_d;
	logic        ever_q, ever_d;
	logic [7:0]  chr_q, chr_d;
	logic        two_q, two_d;
	logic        lowem_q, lowem_d;

	logic        inverted;
	logic        tick;
	logic [5:0]  div_limit;
	logic [31:0] field;
	logic [5:0]  lsb_pos;
	logic [5:0]  mask_ones;

	// Register writes and their address decode
	always_comb begin
		setup_d     = setup_q;
		mode_d      = mode_q;
		title_d     = title_q;
		unit_d      = unit_q;
		data_mask_d = data_mask_q;
		sign_mask_d = sign_mask_q;
		if (reg_wr_stb) begin
			if (reg_addr == OFS_LINE_FREQ_SETUP) begin
				setup_d = reg_wr_data[3:0];
			end
			if (reg_addr == OFS_SET_MODE_CODE) begin
				mode_d = reg_wr_data[3:0];
			end
			if (reg_addr >= OFS_TITLE_FIRST && reg_addr <= OFS_TITLE_LAST) begin
				title_d[4'(reg_addr - OFS_TITLE_FIRST)] = reg_wr_data;
			end
			if (reg_addr >= OFS_UNIT_FIRST && reg_addr <= OFS_UNIT_LAST) begin
				unit_d[3'(reg_addr - OFS_UNIT_FIRST)] = reg_wr_data;
			end
			if (reg_addr >= OFS_DATA_MASK_B0 && reg_addr <= OFS_DATA_MASK_B3) begin
				data_mask_d[8*(3-int'(reg_addr - OFS_DATA_MASK_B0)) +: 8] = reg_wr_data;
			end
			if (reg_addr >= OFS_SIGN_MASK_B0 && reg_addr <= OFS_SIGN_MASK_B3) begin
				sign_mask_d[8*(3-int'(reg_addr - OFS_SIGN_MASK_B0)) +: 8] = reg_wr_data;
			end
		end
	end

	// Register read mux; data stands for one cycle only
	always_comb begin
		rd_d = 8'h00;
		if (reg_rd_stb) begin
			if (reg_addr == OFS_LINE_FREQ_SETUP) begin
				rd_d = {4'h0, setup_q};
			end else if (reg_addr == OFS_SET_MODE_CODE) begin
				rd_d = {4'h0, mode_q};
			end else if (reg_addr >= OFS_TITLE_FIRST && reg_addr <= OFS_TITLE_LAST) begin
				rd_d = title_q[4'(reg_addr - OFS_TITLE_FIRST)];
			end else if (reg_addr >= OFS_UNIT_FIRST && reg_addr <= OFS_UNIT_LAST) begin
				rd_d = unit_q[3'(reg_addr - OFS_UNIT_FIRST)];
			end else if (reg_addr >= OFS_DATA_MASK_B0 && reg_addr <= OFS_DATA_MASK_B3) begin
				rd_d = data_mask_q[8*(3-int'(reg_addr - OFS_DATA_MASK_B0)) +: 8];
			end else if (reg_addr >= OFS_SIGN_MASK_B0 && reg_addr <= OFS_SIGN_MASK_B3) begin
				rd_d = sign_mask_q[8*(3-int'(reg_addr - OFS_SIGN_MASK_B0)) +: 8];
			end else if (reg_addr == OFS_STATUS) begin
				rd_d = {5'h00, state_q != SMDF_IDLE && state_q != SMDF_WAIT, neg_q, ever_q};
			end else if (reg_addr == OFS_BITS_RECEIVED) begin
				rd_d = {2'b00, len_q};
			end else if (reg_addr == OFS_DATA_LENGTH) begin
				rd_d = {2'b00, mask_ones};
			end else if (reg_addr >= OFS_MAGNITUDE_B0 && reg_addr <= OFS_MAGNITUDE_B3) begin
				rd_d = 8'(32'(mag_q) >> (8*(3-int'(reg_addr - OFS_MAGNITUDE_B0))));
			end
		end
	end

	// Configuration registers; masks clear on reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			setup_q <= RST_LINE_FREQ_SETUP;
			mode_q  <= RST_SET_MODE_CODE;
			for (int i = 0; i < TITLE_CHARS; i++) begin
				title_q[i] <= RST_TEXT_CHAR;
			end
			for (int i = 0; i < UNIT_CHARS; i++) begin
				unit_q[i] <= RST_TEXT_CHAR;
			end
			data_mask_q <= {4{RST_MASK_BYTE}};
			sign_mask_q <= {4{RST_MASK_BYTE}};
			rd_q        <= 8'h00;
		end else begin
			setup_q     <= setup_d;
			mode_q      <= mode_d;
			title_q     <= title_d;
			unit_q      <= unit_d;
			data_mask_q <= data_mask_d;
			sign_mask_q <= sign_mask_d;
			rd_q        <= rd_d;
		end
	end

	// setup code: bit0 lines, bit1 frequency, bits 3:2 divider
	// prescale by four times the selected factor
	always_comb begin
		case (setup_q[3:2])
			2'd0:    div_limit = DIV_LIMIT_A;
			2'd1:    div_limit = DIV_LIMIT_B;
			default: div_limit = DIV_LIMIT_C;	// Codes above B fall here
		endcase
		tick  = (div_q == div_limit);
		div_d = tick ? 6'd0 : div_q + 6'd1;
		two_d = setup_q[0];
		// low frequency selects low emission operation
		lowem_d  = ~setup_q[1];
		// mode D flips strobe polarity and sign sense
		inverted = (mode_q == MODE_DISPLAY_INVERTED);
	end

	// data length and field alignment from the mask
	always_comb begin
		lsb_pos   = 6'd0;
		mask_ones = 6'd0;
		for (int i = WORD_BITS - 1; i >= 0; i--) begin
			if (data_mask_q[i]) begin
				lsb_pos   = 6'(i);
				mask_ones = mask_ones + 6'd1;
			end
		end
		// a contiguous run makes this shift exact
		field = (shift_q & data_mask_q) >> lsb_pos;
	end

	// Capture sequencer: sample, raise strobe, lower strobe
	always_comb begin
		state_d  = state_q;
		bits_d   = bits_q;
		shift_d  = shift_q;
		strobe_d = strobe_q;
		mag_d    = mag_q;
		neg_d    = neg_q;
		valid_d  = 1'b0;
		len_d    = len_q;
		ever_d   = ever_q;
		case (state_q)
			SMDF_IDLE: begin
				if (!word_select_n) begin
					bits_d  = 6'd0;
					shift_d = 32'h0000_0000;
					state_d = SMDF_LOW;
				end
			end
			SMDF_LOW: begin
				// select high ends the word early
				if (word_select_n) begin
					state_d = SMDF_DONE;
				end else if (tick) begin
					// MSB first shifts toward the top
					shift_d  = {shift_q[30:0], serial_bit_in};
					strobe_d = 1'b1;
					state_d  = SMDF_HIGH;
				end
			end
			SMDF_HIGH: begin
				if (tick) begin
					strobe_d = 1'b0;
					bits_d   = bits_q + 6'd1;
					if (word_select_n || bits_q + 6'd1 == WORD_BITS_MAX) begin
						state_d = SMDF_DONE;
					end else begin
						state_d = SMDF_LOW;
					end
				end
			end
			SMDF_DONE: begin
				// right-aligned result held until next word
				mag_d   = MAG_W'(field);
				// single sign mask bit selects the sign
				neg_d   = (|(shift_q & sign_mask_q)) ^ inverted;
				len_d   = bits_q;
				valid_d = 1'b1;
				ever_d  = 1'b1;
				state_d = SMDF_WAIT;
			end
			SMDF_WAIT: begin
				// Full-length word must see select rise first
				if (word_select_n) begin
					state_d = SMDF_IDLE;
				end
			end
			default: begin
				state_d = SMDF_IDLE;
			end
		endcase
		// strobe level on the pin, inverted in mode D only
		pin_d = strobe_d ^ inverted;
	end

	// Capture and setup-decode registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= SMDF_IDLE;
			div_q    <= 6'd0;
			bits_q   <= 6'd0;
			shift_q  <= 32'h0000_0000;
			strobe_q <= 1'b0;
			pin_q    <= 1'b0;
			mag_q    <= '0;
			neg_q    <= 1'b0;
			valid_q  <= 1'b0;
			len_q    <= 6'd0;
			ever_q   <= 1'b0;
			two_q    <= 1'b0;
			lowem_q  <= 1'b1;
		end else begin
			state_q  <= state_d;
			div_q    <= div_d;
			bits_q   <= bits_d;
			shift_q  <= shift_d;
			strobe_q <= strobe_d;
			pin_q    <= pin_d;
			mag_q    <= mag_d;
			neg_q    <= neg_d;
			valid_q  <= valid_d;
			len_q    <= len_d;
			ever_q   <= ever_d;
			two_q    <= two_d;
			lowem_q  <= lowem_d;
		end
	end

	// Character layout for the addressed display cell
	always_comb begin
		logic       line;
		logic [3:0] col;
		logic [3:0] j;
		logic [3:0] dig;
		logic [2:0] k;
		line  = char_index[4];
		col   = char_index[3:0];
		j     = 4'd0;
		dig   = 4'd0;
		k     = (point_after > 3'(DIGITS)) ? 3'(DIGITS) : point_after;
		chr_d = CHR_BLANK;
		if (two_q && !line) begin
			chr_d = title_q[col];
		end else if (two_q == line) begin
			// 1-line module: only line 0 shows, no title
			// data field from the line's first column
			if (col == 4'd0) begin
				// sign in front of the seven digits
				chr_d = neg_q ? CHR_MINUS : CHR_PLUS;
			end else if (col <= DATA_FIELD_LAST) begin
				j = col - 4'd1;
				if (j == {1'b0, k}) begin
					chr_d = CHR_POINT;
				end else begin
					dig   = (j < {1'b0, k}) ? j : j - 4'd1;
					chr_d = CHR_ZERO | {4'h0, bcd_digits[4*(DIGITS-1-int'(dig)) +: 4]};
				end
			end else begin
				chr_d = unit_q[3'(col - DATA_FIELD_LAST)];
			end
			// non-blank unit start takes the last digit cell
			if (col == DATA_FIELD_LAST && unit_q[0] != CHR_BLANK) begin
				chr_d = unit_q[0];
			end
		end
	end

	// Character output register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chr_q <= CHR_BLANK;
		end else begin
			chr_q <= chr_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rd_data   = rd_q;
	assign serial_strobe = pin_q;
	assign magnitude     = mag_q;
	assign sign_negative = neg_q;
	assign result_valid  = valid_q;
	assign two_line_mode = two_q;
	assign low_emission  = lowem_q;
	assign char_code     = chr_q;

endmodule

// *** include/smdf_pkg.sv ***
/*
 * Constants for the serial mask display formatter: register offsets,
 * reset values, divider figures and character codes.
 * Assumes a byte-wide register port and a single 100 MHz clock.
 */
package smdf_pkg;
	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] OFS_LINE_FREQ_SETUP = 8'h00;
	localparam logic [7:0] OFS_SET_MODE_CODE   = 8'h04;
	localparam logic [7:0] OFS_TITLE_FIRST     = 8'h08;
	localparam logic [7:0] OFS_TITLE_LAST      = 8'h17;
	localparam logic [7:0] OFS_UNIT_FIRST      = 8'h18;
	localparam logic [7:0] OFS_UNIT_LAST       = 8'h1f;
	localparam logic [7:0] OFS_DATA_MASK_B0    = 8'h60;
	localparam logic [7:0] OFS_DATA_MASK_B3    = 8'h63;
	localparam logic [7:0] OFS_SIGN_MASK_B0    = 8'h64;
	localparam logic [7:0] OFS_SIGN_MASK_B3    = 8'h67;
	localparam logic [7:0] OFS_STATUS          = 8'h68;
	localparam logic [7:0] OFS_BITS_RECEIVED   = 8'h69;
	localparam logic [7:0] OFS_DATA_LENGTH     = 8'h6a;
	localparam logic [7:0] OFS_MAGNITUDE_B0    = 8'h6b;
	localparam logic [7:0] OFS_MAGNITUDE_B3    = 8'h6e;

	// Reset values
	localparam logic [3:0] RST_LINE_FREQ_SETUP = 4'h0;
	localparam logic [3:0] RST_SET_MODE_CODE   = 4'hc;
	localparam logic [7:0] RST_MASK_BYTE       = 8'h00;
	localparam logic [7:0] RST_TEXT_CHAR       = 8'h20;

	// Mode codes: display-only normal and inverted polarity
	localparam logic [3:0] MODE_DISPLAY_NORMAL   = 4'hc;
	localparam logic [3:0] MODE_DISPLAY_INVERTED = 4'hd;
	localparam logic [3:0] SETUP_LAST_VALID      = 4'hb;

	// Clock divider: fixed prescale times a selected factor
	localparam int DIV_PRESCALE = 4;
	localparam int DIV_MUL_A    = 1;
	localparam int DIV_MUL_B    = 2;
	localparam int DIV_MUL_C    = 16;
	localparam logic [5:0] DIV_LIMIT_A = 6'(DIV_PRESCALE * DIV_MUL_A - 1);
	localparam logic [5:0] DIV_LIMIT_B = 6'(DIV_PRESCALE * DIV_MUL_B - 1);
	localparam logic [5:0] DIV_LIMIT_C = 6'(DIV_PRESCALE * DIV_MUL_C - 1);

	// Word and display geometry
	localparam int         WORD_BITS     = 32;
	localparam logic [5:0] WORD_BITS_MAX = 6'd32;
	localparam int         TITLE_CHARS   = 16;
	localparam int         UNIT_CHARS    = 8;
	localparam int         DIGITS        = 7;
	localparam logic [3:0] DATA_FIELD_LAST = 4'd8;
	localparam logic [7:0] CHR_BLANK = 8'h20;
	localparam logic [7:0] CHR_PLUS  = 8'h2b;
	localparam logic [7:0] CHR_MINUS = 8'h2d;
	localparam logic [7:0] CHR_POINT = 8'h2e;
	localparam logic [7:0] CHR_ZERO  = 8'h30;

	// Capture sequencer states
	typedef enum logic [2:0] {
		SMDF_IDLE = 3'b000,
		SMDF_LOW  = 3'b001,
		SMDF_HIGH = 3'b010,
		SMDF_DONE = 3'b011,
		SMDF_WAIT = 3'b100
	} smdf_state_e;
endpackage

// *** tb/smdf_core_chk.sv ***
/*
 * Port checker for smdf_core: register reads, word results, strobe timing
 * and the character layout. Bound to every smdf_core; sees its ports only.
 */
`timescale 1ns/10ps
module smdf_core_chk
	import smdf_pkg::*;
#(
	parameter int MAG_W = 32	// Magnitude width
) (
	input wire logic                 clock,         // Clock
	input wire logic                 rst_n,         // Reset, low
	input wire logic [7:0]           reg_addr,      // Address
	input wire logic [7:0]           reg_wr_data,   // Write data
	input wire logic                 reg_wr_stb,    // Write strobe
	input wire logic                 reg_rd_stb,    // Read strobe
	input wire logic [7:0]           reg_rd_data,   // Read data
	input wire logic                 word_select_n, // Word select
	input wire logic                 serial_bit_in, // Serial data
	input wire logic                 serial_strobe, // Bit strobe
	input wire logic [MAG_W-1:0]     magnitude,     // Result
	input wire logic                 sign_negative, // Sign
	input wire logic                 result_valid,  // Word done
	input wire logic                 two_line_mode, // 2-line
	input wire logic                 low_emission,  // Low frequency
	input wire logic [4*DIGITS-1:0]  bcd_digits,    // Digits
	input wire logic [2:0]           point_after,   // Point place
	input wire logic [4:0]           char_index,    // Char index
	input wire logic [7:0]           char_code      // Char out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Read port and word result
	a_rdata_idle: assert property (!reg_rd_stb |=> reg_rd_data == 8'h00)
		else $error("read data not zero outside read");
	a_mag_readback: assert property (reg_rd_stb && reg_addr == OFS_MAGNITUDE_B3 |=>
		reg_rd_data == $past(magnitude[7:0])) else $error("magnitude byte read wrong");
	a_valid_pulse: assert property (result_valid |=> !result_valid)
		else $error("result valid longer than one cycle");
	a_mag_held: assert property (!result_valid |-> $stable(magnitude))
		else $error("magnitude moved without result valid");
	// Strobe phases last at least the shortest tick period
	a_strobe_width: assert property ($changed(serial_strobe) |=> $stable(serial_strobe)[*3])
		else $error("strobe phase shorter than four cycles");
	a_setup_decode: assert property (reg_wr_stb && reg_addr == OFS_LINE_FREQ_SETUP |=> ##1
		(two_line_mode == $past(reg_wr_data[0], 2) && low_emission == !$past(reg_wr_data[1], 2)))
		else $error("setup decode wrong");
	// Layout of the data line and the unused line
	a_one_line_blank: assert property ($past(rst_n) && !$past(two_line_mode) && $past(char_index[4])
		|-> char_code == CHR_BLANK) else $error("second line not blank on 1-line module");
	a_sign_char: assert property ($past(rst_n) && $past(char_index) == {$past(two_line_mode), 4'h0}
		|-> char_code == ($past(sign_negative) ? CHR_MINUS : CHR_PLUS)) else $error("sign char wrong");
endmodule

bind smdf_core smdf_core_chk #(.MAG_W(MAG_W)) u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
	.word_select_n(word_select_n), .serial_bit_in(serial_bit_in), .serial_strobe(serial_strobe),
	.magnitude(magnitude), .sign_negative(sign_negative), .result_valid(result_valid),
	.two_line_mode(two_line_mode), .low_emission(low_emission), .bcd_digits(bcd_digits),
	.point_after(point_after), .char_index(char_index), .char_code(char_code));

// *** tb/smdf_sender.sv ***
/*
 * Model of the instrument that shifts serial words into the block.
 * Assumes one go pulse per word and the active strobe level on strobe_act.
 */
`timescale 1ns/10ps
module smdf_sender (
	input  wire logic        clock,         // Clock
	input  wire logic        rst_n,         // Reset, low
	input  wire logic        serial_strobe, // Acknowledge from block
	input  wire logic        strobe_act,    // Active strobe level
	input  wire logic        go,            // Start one word
	input  wire logic [31:0] word,          // Word, right-justified
	input  wire logic [5:0]  nbits,         // Bits to send
	output logic             word_select_n, // Word select, low active
	output logic             serial_bit_in  // Serial data
);
	// Each bit held until acknowledged; released line shows the inverse
	initial begin
		word_select_n = 1'b1;
		serial_bit_in = 1'b0;
		forever begin
			@(posedge clock);
			if (go === 1'b1 && rst_n === 1'b1) begin
				word_select_n <= 1'b0;
				serial_bit_in <= word[nbits-1];
				for (int i = int'(nbits) - 1; i >= 0; i--) begin
					do @(posedge clock); while (serial_strobe !== strobe_act);
					if (i > 0)
						serial_bit_in <= word[i-1];
					else begin
						word_select_n <= 1'b1;
						serial_bit_in <= ~word[0];
					end
					// A strobe lasts a whole tick; wait it out or bits get skipped
					do @(posedge clock); while (serial_strobe === strobe_act);
				end
			end
		end
	end
endmodule

// *** tb/smdf_tb_top.sv ***
/*
 * Self-checking bench for smdf_core with a serial sender model.
 * Assumes the checker is bound in; registers reached over the strobe port.
 */
`timescale 1ns/10ps
module smdf_tb_top
	import smdf_pkg::*;
;
	logic        clock, rst_n, reg_wr_stb, reg_rd_stb, go, md;
	logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, char_code;
	logic        word_select_n, serial_bit_in, serial_strobe, sign_negative;
	logic        result_valid, two_line_mode, low_emission, sign_exp;
	logic [31:0] magnitude, word;
	logic [27:0] bcd_digits;
	logic [2:0]  point_after;
	logic [4:0]  char_index;
	logic [5:0]  nbits;
	int          num_errors, n_compared;

	smdf_core DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
		.word_select_n(word_select_n), .serial_bit_in(serial_bit_in), .serial_strobe(serial_strobe),
		.magnitude(magnitude), .sign_negative(sign_negative), .result_valid(result_valid),
		.two_line_mode(two_line_mode), .low_emission(low_emission), .bcd_digits(bcd_digits),
		.point_after(point_after), .char_index(char_index), .char_code(char_code));
	smdf_sender u_sender (.clock(clock), .rst_n(rst_n), .serial_strobe(serial_strobe), .strobe_act(~md),
		.go(go), .word(word), .nbits(nbits), .word_select_n(word_select_n), .serial_bit_in(serial_bit_in));

	// Free-running clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_stb <= 1'b1;
		@(posedge clock);
		reg_wr_stb <= 1'b0;
	endtask

	task automatic rd_chk(logic [7:0] a, logic [7:0] exp, string what);
		@(posedge clock);
		reg_addr <= a;
		reg_rd_stb <= 1'b1;
		@(posedge clock);
		reg_rd_stb <= 1'b0;
		#1 check(reg_rd_data, exp, what);
	endtask

	task automatic chr_chk(logic [4:0] idx, logic [7:0] exp, string what);
		@(posedge clock);
		char_index <= idx;
		@(posedge clock);
		#1 check(char_code, exp, what);
	endtask

	// One word through the sender; strobes, width and result judged here
	task automatic run_word(logic [3:0] setup, logic mode_d, logic [31:0] w, int nb);
		logic [31:0] eff;
		int          strobes, width, n;
		logic        act, prev;
		eff = (nb == 32) ? w : w & ((32'h1 << nb) - 32'h1);
		n = (setup[3:2] == 2'b00) ? 4 : (setup[3:2] == 2'b01) ? 8 : 64;
		wr(OFS_LINE_FREQ_SETUP, {4'h0, setup});
		wr(OFS_SET_MODE_CODE, {4'h0, mode_d ? MODE_DISPLAY_INVERTED : MODE_DISPLAY_NORMAL});
		md = mode_d;
		word = w;
		nbits = 6'(nb);
		repeat (2) @(posedge clock);
		#1 check(serial_strobe, mode_d, "strobe rest level");
		@(posedge clock);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		strobes = 0;
		width = 0;
		prev = 1'b0;
		// Count strobe pulses and the width of the first one
		for (int c = 0; c < 20000 && result_valid !== 1'b1; c++) begin
			@(posedge clock);
			#1;
			act = (serial_strobe !== mode_d);
			if (act && !prev)
				strobes++;
			if (act && strobes == 1)
				width++;
			prev = act;
		end
		check(result_valid, 1'b1, "word completed");
		check(width, n, "strobe width");
		check(strobes, nb, "strobe count");
		check(magnitude, (eff >> 4) & 32'h0000ffff, "magnitude");
		check(sign_negative, eff[22] ^ mode_d, "sign");
		sign_exp = eff[22] ^ mode_d;
		rd_chk(OFS_BITS_RECEIVED, 8'(nb), "bits received");
		rd_chk(OFS_MAGNITUDE_B3, 8'(eff >> 4), "magnitude low byte");
		$display("test word of %0d bits done", nb);
	endtask

	task automatic t_masks();
		logic [7:0] dm [4] = '{8'h00, 8'h0f, 8'hff, 8'hf0};
		logic [7:0] sm [4] = '{8'h00, 8'h40, 8'h00, 8'h00};
		for (int a = 8'h60; a <= 8'h67; a++)
			rd_chk(8'(a), RST_MASK_BYTE, "mask reset");
		wr(8'h80, 8'hff);
		rd_chk(8'h80, 8'h00, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DATA_MASK_B0 + 8'(i), dm[i]);
			wr(OFS_SIGN_MASK_B0 + 8'(i), sm[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rd_chk(OFS_DATA_MASK_B0 + 8'(i), dm[i], "data mask byte");
			rd_chk(OFS_SIGN_MASK_B0 + 8'(i), sm[i], "sign mask byte");
		end
		rd_chk(OFS_DATA_LENGTH, 8'd16, "data length");
		$display("test masks done");
	endtask

	task automatic t_setup();
		for (int s = 0; s <= 11; s++) begin
			wr(OFS_LINE_FREQ_SETUP, 8'(s));
			repeat (3) @(posedge clock);
			#1 check(two_line_mode, s[0], "line count");
			check(low_emission, !s[1], "emission mode");
		end
		$display("test setup codes done");
	endtask

	task automatic t_display();
		wr(OFS_LINE_FREQ_SETUP, 8'h01);
		for (int i = 0; i < 16; i++)
			wr(OFS_TITLE_FIRST + 8'(i), 8'h41 + 8'(i));
		for (int i = 0; i < 16; i++)
			chr_chk(5'(i), 8'h41 + 8'(i), "title char");
		chr_chk(5'h10, sign_exp ? CHR_MINUS : CHR_PLUS, "sign char");
		chr_chk(5'h11, 8'h31, "first digit");
		chr_chk(5'h12, CHR_POINT, "point");
		chr_chk(5'h18, 8'h37, "last digit");
		wr(OFS_UNIT_FIRST, 8'h4b);
		chr_chk(5'h18, 8'h4b, "unit over digit");
		wr(OFS_LINE_FREQ_SETUP, 8'h00);
		repeat (2) @(posedge clock);
		chr_chk(5'h00, sign_exp ? CHR_MINUS : CHR_PLUS, "one line sign");
		chr_chk(5'h10, CHR_BLANK, "no title");
		$display("test display done");
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst_n, reg_wr_stb, reg_rd_stb, go, md} = 5'b00000;
		{reg_addr, reg_wr_data, char_index, nbits, word} = '0;
		bcd_digits = 28'h1234567;
		point_after = 3'd1;
		sign_exp = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_masks();
		run_word(4'h0, 1'b0, 32'hff45a5c3, 23);
		run_word(4'h6, 1'b0, 32'h12345678, 32);
		run_word(4'h9, 1'b1, 32'h003a5a5a, 23);
		t_setup();
		t_display();
		tally_and_finish();
	end

	// Hang guard, far beyond the few thousand cycles expected
	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
